/* lasr_ackid_regs.sv */
// per-port local ackID tracking register bank with configuration access
//
// Behaviour
// - one read returns the receive and transmit ackIDs of the port together.
// - bits 24..28 hold the writable next expected receive ackID.
// - a write of the expected receive ackID takes effect in the port at once.
// - the expected receive ackID can also be preset over the serial config path.
// - a preset of a nonzero ackID stops the port exchanging packets until reset.
// - bits 8..12 read-only show the oldest unacknowledged transmitted ackID.
// - bits 0..4 hold the writable ackID of the next transmitted packet.
// - writing the next transmit ackID also loads the oldest unacknowledged ackID.
// - a receive error or retry during that write keeps it off the next packet.
// - otherwise a new transmit ackID is always used, normal or error state.
// - reset clears the whole register to zero.
// - sixteen port copies sit at 0x148 plus 0x20 per port.
`timescale 1ns/1ns
`include "lasr_regs.svh"

module lasr_ackid_regs #(
  parameter int NUM_PORTS = `LASR_NUM_PORTS
) (
  input  wire logic                                   CLOCK,
  input  wire logic                                   RESET_N,
  input  wire lasr_pkg::lasr_cfg_req_t                CFG_REQ,
  output      logic [31:0]                            CFG_RDATA,
  output      logic                                   CFG_ACK,
  output      logic                                   CFG_HIT,
  input  wire lasr_pkg::lasr_preset_t                 PRESET,
  input  wire lasr_pkg::lasr_eng_t    [NUM_PORTS-1:0] ENG_IN,
  output      lasr_pkg::lasr_to_eng_t [NUM_PORTS-1:0] ENG_OUT
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic        hit;
  } lasr_bus_t;

  lasr_bus_t state_reg;
  lasr_bus_t state_next;

  logic [11:0]                          off;
  logic                                 sel_hit;
  logic [3:0]                           sel_port;
  lasr_pkg::lasr_ids_t                  wr_ids;
  lasr_pkg::lasr_ids_t [NUM_PORTS-1:0]  port_ids;
  lasr_pkg::lasr_id_t  [NUM_PORTS-1:0]  port_tx;
  logic                [NUM_PORTS-1:0]  port_blk;

  // address decode over the per-port copies
  always_comb begin
    off      = CFG_REQ.addr - `LASR_BASE_OFF;
    sel_port = off[`LASR_STRIDE_LOG2+3:`LASR_STRIDE_LOG2];
    sel_hit  = (CFG_REQ.addr >= `LASR_BASE_OFF)
             && (off[`LASR_STRIDE_LOG2-1:0] == 5'h00)
             && (off[11:`LASR_STRIDE_LOG2] < 7'(NUM_PORTS));
  end

  // only the two writable id fields, inbound and outbound, are taken from the write word
  always_comb begin
    wr_ids             = '0;
    wr_ids.inbound     = CFG_REQ.wdata[`LASR_INB_LSB +: `LASR_ID_W];
    wr_ids.outbound    = CFG_REQ.wdata[`LASR_OUTB_LSB +: `LASR_ID_W];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      lasr_port_track u_trk (
        .clock     (CLOCK),
        .reset_n   (RESET_N),
        .wr        (CFG_REQ.wr && sel_hit && (sel_port == 4'(g))),
        .wr_ids    (wr_ids),
        .preset    (PRESET.valid && (PRESET.port == 4'(g))),
        .preset_id (PRESET.id),
        .eng       (ENG_IN[g]),
        .ids       (port_ids[g]),
        .tx_id     (port_tx[g]),
        .blocked   (port_blk[g])
      );
      assign ENG_OUT[g].rx_expect_id = port_ids[g].inbound;
      assign ENG_OUT[g].tx_next_id   = port_tx[g];
      assign ENG_OUT[g].tx_oldest_id = port_ids[g].outstanding;
      assign ENG_OUT[g].exchange_en  = !port_blk[g];
    end
  endgenerate

  // read word assembly and access answer
  always_comb begin
    state_next       = state_reg;
    state_next.ack   = CFG_REQ.wr || CFG_REQ.rd;
    state_next.hit   = (CFG_REQ.wr || CFG_REQ.rd) && sel_hit;
    if (CFG_REQ.rd) begin
      state_next.rdata = `LASR_RESET_VAL;
      if (sel_hit) begin
        state_next.rdata[`LASR_INB_LSB +: `LASR_ID_W]  = port_ids[sel_port].inbound;
        state_next.rdata[`LASR_OUTS_LSB +: `LASR_ID_W] = port_ids[sel_port].outstanding;
        state_next.rdata[`LASR_OUTB_LSB +: `LASR_ID_W] = port_ids[sel_port].outbound;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign CFG_RDATA = state_reg.rdata;
  assign CFG_ACK   = state_reg.ack;
  assign CFG_HIT   = state_reg.hit;

endmodule

/* lasr_regs.svh */
// register offsets, field positions, reset values for the ackID tracking bank
`ifndef LASR_REGS_SVH
`define LASR_REGS_SVH

`define LASR_ADDR_W       12
`define LASR_NUM_PORTS    16
`define LASR_BASE_OFF     12'h148
`define LASR_PORT_STRIDE  12'h020
`define LASR_STRIDE_LOG2  5
`define LASR_ID_W         5
`define LASR_INB_LSB      24
`define LASR_OUTS_LSB     8
`define LASR_OUTB_LSB     0
`define LASR_RESET_VAL    32'h0000_0000
`define LASR_ID_RESET     5'h00

`endif

/* lasr_pkg.sv */
// types shared by the ackID tracking bank
package lasr_pkg;

  typedef logic [4:0] lasr_id_t;

  // three identifier fields of one port
  typedef struct packed {
    lasr_id_t inbound;
    lasr_id_t outstanding;
    lasr_id_t outbound;
  } lasr_ids_t;

  // per-port events from the ackID protocol engine
  typedef struct packed {
    logic rx_accept;
    logic tx_send;
    logic tx_acked;
    logic rx_err_retry;
  } lasr_eng_t;

  // per-port values handed back to the engine
  typedef struct packed {
    lasr_id_t rx_expect_id;
    lasr_id_t tx_next_id;
    lasr_id_t tx_oldest_id;
    logic     exchange_en;
  } lasr_to_eng_t;

  // configuration access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } lasr_cfg_req_t;

  // test preset from the serial configuration interface
  typedef struct packed {
    logic     valid;
    logic [3:0] port;
    lasr_id_t id;
  } lasr_preset_t;

endpackage

/* lasr_port_track.sv */
// ackID tracking state of one port
`timescale 1ns/1ns
`include "lasr_regs.svh"

module lasr_port_track (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               wr,
  input  wire lasr_pkg::lasr_ids_t wr_ids,
  input  wire logic               preset,
  input  wire lasr_pkg::lasr_id_t  preset_id,
  input  wire lasr_pkg::lasr_eng_t eng,
  output      lasr_pkg::lasr_ids_t ids,
  output      lasr_pkg::lasr_id_t  tx_id,
  output      logic               blocked
);

  typedef struct packed {
    lasr_pkg::lasr_ids_t ids;
    lasr_pkg::lasr_id_t  held;
    lasr_pkg::lasr_id_t  tx_id;
    logic               skip;
    logic               blocked;
  } lasr_trk_t;

  lasr_trk_t state_reg;
  lasr_trk_t state_next;

  always_comb begin
    state_next = state_reg;
    if (eng.rx_accept) begin
      state_next.ids.inbound = state_reg.ids.inbound + 5'h01;
    end
    if (eng.tx_acked) begin
      state_next.ids.outstanding = state_reg.ids.outstanding + 5'h01;
    end
    if (eng.tx_send) begin
      // a skipped write gives way to the engine's own value once
      if (state_reg.skip) begin
        state_next.ids.outbound = state_reg.held + 5'h01;
        state_next.skip         = 1'b0;
      end else begin
        state_next.ids.outbound = state_reg.ids.outbound + 5'h01;
      end
    end
    if (preset) begin
      state_next.ids.inbound = preset_id;
      if (preset_id != `LASR_ID_RESET) begin
        state_next.blocked = 1'b1;
      end
    end
    if (wr) begin
      state_next.ids.inbound     = wr_ids.inbound;
      state_next.ids.outbound    = wr_ids.outbound;
      state_next.ids.outstanding = wr_ids.outbound;
      if (eng.rx_err_retry) begin
        state_next.skip = 1'b1;
        state_next.held = eng.tx_send ? state_reg.tx_id + 5'h01 : state_reg.tx_id;
      end else begin
        state_next.skip = 1'b0;
      end
    end
    state_next.tx_id = state_next.skip ? state_next.held : state_next.ids.outbound;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ids     = state_reg.ids;
  assign tx_id   = state_reg.tx_id;
  assign blocked = state_reg.blocked;

endmodule

/* lasr_ackid_monitor.sv */
// port assertions for the ackID tracking bank
`timescale 1ns/1ns
module lasr_ackid_monitor #(
  parameter int NUM_PORTS = 16
) (
  input wire logic                                   CLOCK,
  input wire logic                                   RESET_N,
  input wire lasr_pkg::lasr_cfg_req_t                CFG_REQ,
  input wire logic [31:0]                            CFG_RDATA,
  input wire logic                                   CFG_ACK,
  input wire logic                                   CFG_HIT,
  input wire lasr_pkg::lasr_preset_t                 PRESET,
  input wire lasr_pkg::lasr_eng_t    [NUM_PORTS-1:0] ENG_IN,
  input wire lasr_pkg::lasr_to_eng_t [NUM_PORTS-1:0] ENG_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic w0;
  assign w0 = CFG_REQ.wr && CFG_REQ.addr == 12'h148;
  property p_ack; (CFG_REQ.wr || CFG_REQ.rd) |=> CFG_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_resv; CFG_ACK |-> (CFG_RDATA & 32'hE0FF_E0E0) == 32'h0000_0000; endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_miss; CFG_REQ.rd && CFG_REQ.addr[4:0] != 5'h08 |=> !CFG_HIT && CFG_RDATA == 0;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped hit");
  property p_win; w0 |=> ENG_OUT[0].rx_expect_id == $past(CFG_REQ.wdata[28:24]); endproperty
  a_win: assert property (p_win) else $error("rx id not applied");
  property p_wout; w0 && !ENG_IN[0].rx_err_retry |=> ENG_OUT[0].tx_next_id ==
    $past(CFG_REQ.wdata[4:0]) && ENG_OUT[0].tx_oldest_id == $past(CFG_REQ.wdata[4:0]);
  endproperty
  a_wout: assert property (p_wout) else $error("tx id not applied");
  property p_skip; w0 && ENG_IN[0].rx_err_retry && !ENG_IN[0].tx_send |=>
    $stable(ENG_OUT[0].tx_next_id); endproperty
  a_skip: assert property (p_skip) else $error("skip not kept");
  property p_send; ENG_IN[0].tx_send && !w0 |=>
    ENG_OUT[0].tx_next_id == 5'($past(ENG_OUT[0].tx_next_id) + 5'h01); endproperty
  a_send: assert property (p_send) else $error("tx id not stepped");
  property p_pre; PRESET.valid && PRESET.id != 5'h00 |=>
    !ENG_OUT[$past(PRESET.port)].exchange_en; endproperty
  a_pre: assert property (p_pre) else $error("exchange not blocked");
endmodule

/* lasr_link_partner.sv */
// link partner model driving one port's engine events
`timescale 1ns/1ns
module lasr_link_partner (
  input  wire logic                clock,
  input  wire logic                go,
  input  wire logic                err,
  output      lasr_pkg::lasr_eng_t eng
);
  logic pend_reg;
  always_ff @(posedge clock) pend_reg <= go;
  // one packet each way per go, ack a cycle later
  assign eng = '{rx_accept: go, tx_send: go, tx_acked: pend_reg, rx_err_retry: err};
endmodule

/* tb_link_ackid_status_register.sv */
// self-checking testbench for the ackID tracking bank
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_link_ackid_status_register;
  logic                          CLOCK, RESET_N, go, err, hit, ack;
  logic [31:0]                   rdata;
  lasr_pkg::lasr_cfg_req_t       req;
  lasr_pkg::lasr_preset_t        pre;
  lasr_pkg::lasr_eng_t           eng_p;
  lasr_pkg::lasr_eng_t    [15:0] eng_in;
  lasr_pkg::lasr_to_eng_t [15:0] eng_out;
  int                            bad_count, checks_done;
  assign eng_in = {60'h0, eng_p};
  lasr_link_partner i_lasr_link_partner (.clock(CLOCK), .go(go), .err(err), .eng(eng_p));
  lasr_ackid_regs i_lasr_ackid_regs (.CLOCK(CLOCK), .RESET_N(RESET_N), .CFG_REQ(req),
    .CFG_RDATA(rdata), .CFG_ACK(ack), .CFG_HIT(hit), .PRESET(pre), .ENG_IN(eng_in),
    .ENG_OUT(eng_out));
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(negedge CLOCK);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    err = e;
    @(negedge CLOCK);
    req = '0;
    err = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    acc(1'b0, a, 32'h0000_0000, 1'b0);
    `CHK({hit, rdata}, e)
    `CHK(ack, 1'b1)
  endtask
  task automatic pkt;
    @(negedge CLOCK);
    go = 1'b1;
    @(negedge CLOCK);
    go = 1'b0;
  endtask
  task automatic rst;
    RESET_N = 1'b0;
    repeat (20) @(negedge CLOCK);
    RESET_N = 1'b1;
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (2000) @(posedge CLOCK);
    bad_count++;
    conclude();
  end
  initial begin
    go = 1'b0;
    err = 1'b0;
    req = '0;
    pre = '0;
    rst();
    rd(12'h148, 33'h1_0000_0000);
    rd(12'h328, 33'h1_0000_0000);
    `CHK(eng_out[0].exchange_en, 1'b1)
    acc(1'b1, 12'h148, 32'hFFFF_FFFF, 1'b0);
    rd(12'h148, 33'h1_1F00_1F1F);
    `CHK(eng_out[0], {5'h1F, 5'h1F, 5'h1F, 1'b1})
    rd(12'h14C, 33'h0_0000_0000);
    acc(1'b1, 12'h16C, 32'hFFFF_FFFF, 1'b0);
    rd(12'h168, 33'h1_0000_0000);
    acc(1'b1, 12'h148, 32'h1E00_001F, 1'b0);
    repeat (3) pkt();
    rd(12'h148, 33'h1_0100_0202);
    acc(1'b1, 12'h148, 32'h0000_0005, 1'b1);
    rd(12'h148, 33'h1_0000_0505);
    `CHK(eng_out[0].tx_next_id, 5'h02)
    pkt();
    `CHK(eng_out[0].tx_next_id, 5'h03)
    acc(1'b1, 12'h148, 32'h0000_0009, 1'b0);
    `CHK(eng_out[0].tx_next_id, 5'h09)
    @(negedge CLOCK);
    pre = '{valid: 1'b1, port: 4'h2, id: 5'h03};
    @(negedge CLOCK);
    pre = '0;
    rd(12'h188, 33'h1_0300_0000);
    `CHK(eng_out[2].exchange_en, 1'b0)
    rst();
    `CHK(eng_out[2], 16'h0001)
    rd(12'h148, 33'h1_0000_0000);
    conclude();
  end
endmodule
bind lasr_ackid_regs lasr_ackid_monitor #(.NUM_PORTS(NUM_PORTS)) i_lasr_ackid_monitor (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA),
  .CFG_ACK(CFG_ACK), .CFG_HIT(CFG_HIT), .PRESET(PRESET), .ENG_IN(ENG_IN), .ENG_OUT(ENG_OUT));
